// File: design/bac_consts.svh
// constants for branch target and cycle accounting block
// assumes one cpu clock domain; included by bare name
`ifndef BAC_CONSTS_SVH
`define BAC_CONSTS_SVH
`define BAC_PEN_ZERO      8'h00
`define BAC_PEN_ODD_WORD  8'h02
`define BAC_PEN_ODD_LONG  8'h04
`define BAC_PEN_EXT_BYTE  8'h01
`define BAC_PEN_EXT_LONG  8'h02
`define BAC_PEN_SLOW_WORD 8'h04
`define BAC_PEN_SLOW_LONG 8'h08
`define BAC_FETCH_INT     8'h02
`define BAC_FETCH_EXT     8'h03
`define BAC_CNT_W         16
`define BAC_ACC_ONE       8'h01
`define BAC_ACC_TWO       8'h02
`define BAC_ACC_FOUR      8'h04
`endif

// File: design/bac_pkg.sv
// types for branch target and cycle accounting block
// no surrounding assumptions beyond the consts header
package bac_pkg;
  typedef enum logic [2:0] {
    BAC_BR_REL, BAC_BR_ACC, BAC_BR_CTX, BAC_BR_MEM, BAC_DATA_ACC
  } bac_kind_t;
  typedef enum logic [1:0] {BAC_SZ_BYTE, BAC_SZ_WORD, BAC_SZ_LONG} bac_size_t;
  typedef enum logic [1:0] {BAC_BUS_REG, BAC_BUS_INT, BAC_BUS_EXT16, BAC_BUS_EXT8} bac_bus_t;
endpackage : bac_pkg

// File: design/bac_branch_addr_cycle_timing.sv
// branch target generation and execution cycle accounting
// core drives one-cycle requests on clk; memory word for indirect branch
// arrives on the same clock from the core's own read path
`timescale 1ns/100ps
`default_nettype none
`include "bac_consts.svh"
module bac_branch_addr_cycle_timing
  import bac_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  // address request
  input  wire logic            addr_req,
  input  wire bac_kind_t       addr_kind,
  input  wire logic [15:0]     pc,
  input  wire logic [7:0]      rel_offset,
  input  wire logic [15:0]     accumulator_low_half,
  input  wire logic [7:0]      code_bank_select,
  input  wire logic [7:0]      data_bank_select,
  input  wire logic [23:0]     ea_addr,
  input  wire logic [15:0]     mem_word,
  output logic                 addr_valid,
  output logic [23:0]          target_addr,
  output logic                 rd_req,
  output logic [23:0]          rd_addr,
  // cycle accounting
  input  wire logic            insn_start,
  input  wire logic [7:0]      base_cycles,
  input  wire logic            fetch_unit,
  input  wire bac_bus_t        fetch_bus,
  input  wire logic            op_access,
  input  wire bac_bus_t        op_bus,
  input  wire bac_size_t       op_size,
  input  wire logic            op_odd,
  input  wire logic            wait_cycle,
  input  wire logic            intermittent_en,
  input  wire logic            cpu_halt_len_bit0,
  input  wire logic            cpu_halt_len_bit1,
  input  wire logic            insn_end,
  output logic [15:0]          cycle_total,
  output logic                 cycle_valid
);

  // operand extra cycles by bus, size and alignment
  function automatic logic [7:0] op_pen(input bac_bus_t b, input bac_size_t s,
                                        input logic odd);
    logic [7:0] r;
    r = `BAC_PEN_ZERO;
    if (b == BAC_BUS_REG) begin
      r = `BAC_PEN_ZERO;
    end else if (b == BAC_BUS_INT) begin
      if (odd && s == BAC_SZ_WORD) r = `BAC_PEN_ODD_WORD;
      else if (odd && s == BAC_SZ_LONG) r = `BAC_PEN_ODD_LONG;
    end else begin
      if (s == BAC_SZ_BYTE) r = `BAC_PEN_EXT_BYTE;
      else if (b == BAC_BUS_EXT16 && !odd && s == BAC_SZ_WORD) r = `BAC_PEN_EXT_BYTE;
      else if (b == BAC_BUS_EXT16 && !odd) r = `BAC_PEN_EXT_LONG;
      else if (s == BAC_SZ_WORD) r = `BAC_PEN_SLOW_WORD;
      else r = `BAC_PEN_SLOW_LONG;
    end
    return r;
  endfunction : op_pen

  // number of accesses an operand takes
  function automatic logic [7:0] op_acc(input bac_bus_t b, input bac_size_t s,
                                        input logic odd);
    logic slow;
    logic [7:0] r;
    slow = (odd && b != BAC_BUS_REG) || (b == BAC_BUS_EXT8);
    r = `BAC_ACC_ONE;
    if (s == BAC_SZ_WORD) r = slow ? `BAC_ACC_TWO : `BAC_ACC_ONE;
    else if (s == BAC_SZ_LONG) r = slow ? `BAC_ACC_FOUR : `BAC_ACC_TWO;
    return r;
  endfunction : op_acc

  // fetch correction per unit; ext8 units are bytes, others words
  function automatic logic [7:0] fetch_pen(input bac_bus_t b);
    logic [7:0] r;
    r = `BAC_FETCH_EXT;
    if (b == BAC_BUS_INT || b == BAC_BUS_REG) r = `BAC_FETCH_INT;
    return r;
  endfunction : fetch_pen

  // address generation state
  logic        addr_valid_ff, nxt_addr_valid;
  logic [23:0] target_addr_ff, nxt_target_addr;
  logic        rd_req_ff, nxt_rd_req;
  logic [23:0] rd_addr_ff, nxt_rd_addr;
  logic        mem_wait_ff, nxt_mem_wait;
  logic [7:0]  mem_bank_ff, nxt_mem_bank;
  logic [15:0] rel_sum;

  // sign extension keeps backward branches; carry dropped by 16-bit sum
  assign rel_sum = pc + {{8{rel_offset[7]}}, rel_offset};

  always_comb begin
    nxt_addr_valid  = 1'b0;
    nxt_target_addr = target_addr_ff;
    nxt_rd_req      = 1'b0;
    nxt_rd_addr     = rd_addr_ff;
    nxt_mem_wait    = mem_wait_ff;
    nxt_mem_bank    = mem_bank_ff;
    if (mem_wait_ff && rd_req_ff) begin
      // word answered during the read pulse becomes target, bank stays code bank
      nxt_addr_valid  = 1'b1;
      nxt_target_addr = {mem_bank_ff, mem_word};
      nxt_mem_wait    = 1'b0;
    end else if (addr_req && !mem_wait_ff) begin
      case (addr_kind)
        BAC_BR_REL: begin
          nxt_addr_valid  = 1'b1;
          nxt_target_addr = {code_bank_select, rel_sum};
        end
        BAC_BR_ACC: begin
          nxt_addr_valid  = 1'b1;
          nxt_target_addr = {code_bank_select, accumulator_low_half};
        end
        BAC_BR_CTX: begin
          nxt_addr_valid  = 1'b1;
          nxt_target_addr = {data_bank_select, accumulator_low_half};
        end
        BAC_DATA_ACC: begin
          nxt_addr_valid  = 1'b1;
          nxt_target_addr = {data_bank_select, accumulator_low_half};
        end
        BAC_BR_MEM: begin
          nxt_rd_req   = 1'b1;
          nxt_rd_addr  = ea_addr;
          nxt_mem_wait = 1'b1;
          nxt_mem_bank = code_bank_select;
        end
        default: nxt_addr_valid = 1'b0;
      endcase
    end
  end

  // address registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_valid_ff  <= 1'b0;
      target_addr_ff <= 24'h000000;
      rd_req_ff      <= 1'b0;
      rd_addr_ff     <= 24'h000000;
      mem_wait_ff    <= 1'b0;
      mem_bank_ff    <= 8'h00;
    end else begin
      addr_valid_ff  <= nxt_addr_valid;
      target_addr_ff <= nxt_target_addr;
      rd_req_ff      <= nxt_rd_req;
      rd_addr_ff     <= nxt_rd_addr;
      mem_wait_ff    <= nxt_mem_wait;
      mem_bank_ff    <= nxt_mem_bank;
    end
  end

  assign addr_valid  = addr_valid_ff;
  assign target_addr = target_addr_ff;
  assign rd_req      = rd_req_ff;
  assign rd_addr     = rd_addr_ff;

  // cycle accounting state
  logic [15:0] acc_ff, nxt_acc;
  logic [15:0] total_ff, nxt_total;
  logic        cvalid_ff, nxt_cvalid;
  logic [1:0]  halt_len;
  logic [15:0] step;
  logic [7:0]  n_acc;

  assign halt_len = {cpu_halt_len_bit1, cpu_halt_len_bit0};

  // sums every correction seen this cycle; fetch term is worst case only
  always_comb begin
    n_acc = `BAC_ACC_ONE;
    step  = 16'h0000;
    if (fetch_unit) begin
      step = step + {8'h00, fetch_pen(fetch_bus)};
      if (intermittent_en) step = step + {14'h0000, halt_len};
    end
    if (op_access) begin
      n_acc = op_acc(op_bus, op_size, op_odd);
      step  = step + {8'h00, op_pen(op_bus, op_size, op_odd)};
      if (intermittent_en) begin
        step = step + 16'(n_acc * halt_len);
      end
    end
    if (wait_cycle) step = step + 16'h0001;
    nxt_acc    = acc_ff + step;
    if (insn_start) nxt_acc = {8'h00, base_cycles} + step;
    nxt_cvalid = insn_end;
    nxt_total  = insn_end ? nxt_acc : total_ff;
  end

  // cycle registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff    <= 16'h0000;
      total_ff  <= 16'h0000;
      cvalid_ff <= 1'b0;
    end else begin
      acc_ff    <= nxt_acc;
      total_ff  <= nxt_total;
      cvalid_ff <= nxt_cvalid;
    end
  end

  assign cycle_total = total_ff;
  assign cycle_valid = cvalid_ff;

  // address results stand one cycle after the request is taken, the indirect target two cycles after
  property p_rel;
    @(posedge clk) disable iff (!arst_n)
    (addr_req && !mem_wait_ff && addr_kind == BAC_BR_REL) |=> addr_valid &&
      target_addr == {$past(code_bank_select), 16'($past(pc) +
      {{8{$past(rel_offset[7])}}, $past(rel_offset)})};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_ctx;
    @(posedge clk) disable iff (!arst_n)
    (addr_req && !mem_wait_ff && addr_kind == BAC_BR_CTX) |=>
      target_addr[23:16] == $past(data_bank_select);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context bank wrong");
  property p_acc;
    @(posedge clk) disable iff (!arst_n)
    (addr_req && !mem_wait_ff && addr_kind == BAC_BR_ACC) |=>
      target_addr == {$past(code_bank_select), $past(accumulator_low_half)};
  endproperty
  a_acc: assert property (p_acc) else $error("acc jump wrong");
  property p_mem;
    @(posedge clk) disable iff (!arst_n)
    (addr_req && !mem_wait_ff && addr_kind == BAC_BR_MEM) |=> rd_req ##1 addr_valid;
  endproperty
  a_mem: assert property (p_mem) else $error("indirect read missing");

  // accumulator steps checked against the correction constants
  property p_wait;
    @(posedge clk) disable iff (!arst_n)
    (!insn_start && wait_cycle && !fetch_unit && !op_access) |=>
      acc_ff == $past(acc_ff) + 16'h0001;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not counted");
  property p_base;
    @(posedge clk) disable iff (!arst_n)
    (insn_start && !wait_cycle && !fetch_unit && !op_access) |=>
      acc_ff == {8'h00, $past(base_cycles)};
  endproperty
  a_base: assert property (p_base) else $error("base count wrong");
  property p_end;
    @(posedge clk) disable iff (!arst_n)
    insn_end |=> cycle_valid && cycle_total == acc_ff;
  endproperty
  a_end: assert property (p_end) else $error("total not reported");
  property p_int_fetch;
    @(posedge clk) disable iff (!arst_n)
    (!insn_start && fetch_unit && fetch_bus == BAC_BUS_INT && !intermittent_en
     && !op_access && !wait_cycle) |=> acc_ff == $past(acc_ff) + 16'h0002;
  endproperty
  a_int_fetch: assert property (p_int_fetch) else $error("fetch charge wrong");
  // data access through the accumulator lands in the data bank
  property p_data;
    @(posedge clk) disable iff (!arst_n)
    (addr_req && !mem_wait_ff && addr_kind == BAC_DATA_ACC) |=>
      addr_valid && target_addr == {$past(data_bank_select), $past(accumulator_low_half)};
  endproperty
  a_data: assert property (p_data) else $error("data address wrong");
  // indirect target is the word shown while the read was asked for
  property p_mem_tgt;
    @(posedge clk) disable iff (!arst_n)
    (rd_req && mem_wait_ff) |=> addr_valid && target_addr[15:0] == $past(mem_word);
  endproperty
  a_mem_tgt: assert property (p_mem_tgt) else $error("indirect target wrong");
  // odd long on internal memory costs the full odd penalty
  property p_odd_long;
    @(posedge clk) disable iff (!arst_n)
    (insn_start && op_access && op_bus == BAC_BUS_INT && op_size == BAC_SZ_LONG && op_odd
     && !intermittent_en && !fetch_unit && !wait_cycle) |=>
      acc_ff == {8'h00, $past(base_cycles)} + {8'h00, `BAC_PEN_ODD_LONG};
  endproperty
  a_odd_long: assert property (p_odd_long) else $error("odd long penalty wrong");
  // byte bus word takes two accesses, each halting the cpu
  property p_halt_op;
    @(posedge clk) disable iff (!arst_n)
    (insn_start && op_access && op_bus == BAC_BUS_EXT8 && op_size == BAC_SZ_WORD
     && intermittent_en && !fetch_unit && !wait_cycle) |=>
      acc_ff == {8'h00, $past(base_cycles)} + {8'h00, `BAC_PEN_SLOW_WORD}
                + {13'h0000, $past(halt_len), 1'b0};
  endproperty
  a_halt_op: assert property (p_halt_op) else $error("halt charge wrong");
  // external word fetch plus one halt when intermittent
  property p_ext_fetch;
    @(posedge clk) disable iff (!arst_n)
    (!insn_start && fetch_unit && fetch_bus == BAC_BUS_EXT16 && !op_access && !wait_cycle)
      |=> acc_ff == $past(acc_ff) + {8'h00, `BAC_FETCH_EXT}
                    + ($past(intermittent_en) ? {14'h0000, $past(halt_len)} : 16'h0000);
  endproperty
  a_ext_fetch: assert property (p_ext_fetch) else $error("fetch halt wrong");

  // main scenarios
  c_ctx: cover property (@(posedge clk) addr_req && addr_kind == BAC_BR_CTX);
  c_wait: cover property (@(posedge clk) wait_cycle && !fetch_unit && !op_access);
  c_rel: cover property (@(posedge clk) addr_req && addr_kind == BAC_BR_REL);
  c_mem: cover property (@(posedge clk) rd_req ##1 addr_valid);
  c_halt: cover property (@(posedge clk) intermittent_en && op_access ##1 insn_end);
endmodule : bac_branch_addr_cycle_timing
`default_nettype wire

// File: tb/bac_mem_model.sv
// partner model: memory answering indirect word reads, ready stalls
// assumes one cpu clock and the block's one-cycle rd_req pulse
`timescale 1ns/100ps
`default_nettype none
module bac_mem_model
  import bac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        rd_req,
  input  wire logic [23:0] rd_addr,
  input  wire logic        op_access,
  input  wire bac_bus_t    op_bus,
  input  wire logic [3:0]  stall_len,
  output logic [15:0]      mem_word,
  output logic             wait_cycle
);
  logic [3:0] cnt_ff;
  logic       ph_ff;
  // word only while asked; churning junk otherwise so stale data is caught
  assign mem_word = rd_req ? (rd_addr[15:0] ^ 16'h5A3C)
                           : ({16{ph_ff}} ^ rd_addr[15:0]);
  // ready held off for stall_len cycles after an external operand
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
      ph_ff  <= 1'b0;
    end else begin
      ph_ff <= ~ph_ff;
      if (op_access && (op_bus == BAC_BUS_EXT16 || op_bus == BAC_BUS_EXT8))
        cnt_ff <= stall_len;
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
  assign wait_cycle = (cnt_ff != 4'h0);
endmodule : bac_mem_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for branch target and cycle accounting
// assumes package, design and memory model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bac_pkg::*;
  logic        clk, arst_n, addr_req, insn_start, fetch_unit, op_access, op_odd;
  logic        intermittent_en, cpu_halt_len_bit0, cpu_halt_len_bit1, insn_end;
  logic        wait_cycle, addr_valid, rd_req, cycle_valid;
  bac_kind_t   addr_kind;
  bac_bus_t    fetch_bus, op_bus;
  bac_size_t   op_size;
  logic [15:0] pc, accumulator_low_half, mem_word, cycle_total;
  logic [7:0]  rel_offset, code_bank_select, data_bank_select, base_cycles;
  logic [23:0] ea_addr, target_addr, rd_addr;
  logic [3:0]  stall_len;
  int          errors = 0;
  int          tests_run = 0;

  bac_branch_addr_cycle_timing DUT (.clk, .arst_n, .addr_req, .addr_kind, .pc,
    .rel_offset, .accumulator_low_half, .code_bank_select, .data_bank_select,
    .ea_addr, .mem_word, .addr_valid, .target_addr, .rd_req, .rd_addr,
    .insn_start, .base_cycles, .fetch_unit, .fetch_bus, .op_access, .op_bus,
    .op_size, .op_odd, .wait_cycle, .intermittent_en, .cpu_halt_len_bit0,
    .cpu_halt_len_bit1, .insn_end, .cycle_total, .cycle_valid);
  bac_mem_model u_mem (.clk, .arst_n, .rd_req, .rd_addr, .op_access, .op_bus,
    .stall_len, .mem_word, .wait_cycle);

  // 25 MHz
  always #20 clk = ~clk;

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // one address request; indirect read takes one extra cycle
  task automatic addr_op(input bac_kind_t k, input logic [23:0] exp);
    addr_req  <= 1'b1;
    addr_kind <= k;
    @(posedge clk);
    addr_req <= 1'b0;
    #1;
    if (k == BAC_BR_MEM) begin
      chk("rd_req", 24'h1, {23'h0, rd_req});
      chk("rd_addr", ea_addr, rd_addr);
      @(posedge clk);
      #1;
    end
    chk("addr_valid", 24'h1, {23'h0, addr_valid});
    chk("target", exp, target_addr);
    @(posedge clk); // next drive lands on a rising edge
  endtask : addr_op

  task automatic t_branch;
    code_bank_select <= 8'h4F;
    data_bank_select <= 8'h21;
    pc <= 16'h3C20;
    rel_offset <= 8'h7F;
    addr_op(BAC_BR_REL, 24'h4F3C9F);
    pc <= 16'hFFF0;
    addr_op(BAC_BR_REL, 24'h4F006F);
    pc <= 16'h0005;
    rel_offset <= 8'h80;
    addr_op(BAC_BR_REL, 24'h4FFF85);
    accumulator_low_half <= 16'h3B20;
    addr_op(BAC_BR_ACC, 24'h4F3B20);
    addr_op(BAC_BR_CTX, 24'h213B20);
    addr_op(BAC_DATA_ACC, 24'h213B20);
    ea_addr <= 24'h217F48;
    addr_op(BAC_BR_MEM, 24'h4F2574);
  endtask : t_branch

  // one instruction: start with operand, nf fetch units, nw stalls, end
  task automatic run_insn(input logic [7:0] base, input bac_bus_t fb, input bac_bus_t ob,
                          input bac_size_t sz, input logic odd, input logic inter,
                          input logic [1:0] hl, input int nf, input int nw);
    logic [15:0] pen, nacc, hk, ex;
    logic        slow;
    int          k;
    slow = (odd && ob != BAC_BUS_REG) || ob == BAC_BUS_EXT8;
    nacc = sz == BAC_SZ_BYTE ? 16'h1 : sz == BAC_SZ_WORD ? (slow ? 16'h2 : 16'h1)
                                                         : (slow ? 16'h4 : 16'h2);
    if (ob == BAC_BUS_REG) pen = 16'h0;
    else if (ob == BAC_BUS_INT) pen = (!odd || sz == BAC_SZ_BYTE) ? 16'h0
                                    : sz == BAC_SZ_WORD ? 16'h2 : 16'h4;
    else pen = sz == BAC_SZ_BYTE ? 16'h1 : sz == BAC_SZ_WORD ? (slow ? 16'h4 : 16'h1)
                                                              : (slow ? 16'h8 : 16'h2);
    hk = inter ? {14'h0, hl} : 16'h0;
    ex = {8'h0, base} + pen + nacc * hk + 16'(nw)
       + 16'(nf) * (((fb == BAC_BUS_EXT16 || fb == BAC_BUS_EXT8) ? 16'h3 : 16'h2) + hk);
    stall_len <= 4'(nw);
    base_cycles <= base;
    fetch_bus <= fb;
    op_bus <= ob;
    op_size <= sz;
    op_odd <= odd;
    intermittent_en <= inter;
    cpu_halt_len_bit1 <= hl[1];
    cpu_halt_len_bit0 <= hl[0];
    insn_start <= 1'b1;
    op_access <= 1'b1;
    @(posedge clk);
    insn_start <= 1'b0;
    op_access <= 1'b0;
    k = nf > nw ? nf : nw;
    for (int i = 0; i < k; i++) begin
      fetch_unit <= (i < nf);
      @(posedge clk);
    end
    fetch_unit <= 1'b0;
    insn_end <= 1'b1;
    @(posedge clk);
    insn_end <= 1'b0;
    #1;
    chk("cycle_valid", 24'h1, {23'h0, cycle_valid});
    chk("cycle_total", {8'h0, ex}, {8'h0, cycle_total});
    @(posedge clk); // next drive lands on a rising edge
  endtask : run_insn

  // every bus, size and alignment; halt bits set but mode off
  task automatic t_ops;
    for (int b = 0; b < 4; b++)
      for (int s = 0; s < 3; s++)
        for (int o = 0; o < 2; o++)
          run_insn(8'h05, BAC_BUS_INT, bac_bus_t'(b[1:0]), bac_size_t'(s[1:0]),
                   o[0], 1'b0, 2'h3, 1, 0);
  endtask : t_ops

  // intermittent mode over all halt lengths, byte bus with ready stalls
  task automatic t_halt;
    for (int h = 0; h < 4; h++)
      run_insn(8'h07, BAC_BUS_EXT8, BAC_BUS_EXT8, BAC_SZ_WORD, 1'b1, 1'b1,
               h[1:0], 2, 2);
    run_insn(8'h03, BAC_BUS_EXT16, BAC_BUS_EXT16, BAC_SZ_LONG, 1'b0, 1'b1,
             2'h1, 3, 0);
    // stalls outlast the fetch so waits stand alone
    run_insn(8'h02, BAC_BUS_EXT16, BAC_BUS_EXT16, BAC_SZ_BYTE, 1'b0, 1'b0,
             2'h0, 1, 3);
  endtask : t_halt

  // no operand and no fetch charge: total is the base count alone
  task automatic t_bare;
    base_cycles <= 8'h0B;
    insn_start  <= 1'b1;
    @(posedge clk);
    insn_start <= 1'b0;
    insn_end   <= 1'b1;
    @(posedge clk);
    insn_end <= 1'b0;
    #1;
    chk("bare cycle_valid", 24'h000001, {23'h0, cycle_valid});
    chk("bare cycle_total", 24'h00000B, {8'h0, cycle_total});
    @(posedge clk);
  endtask : t_bare

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {addr_req, insn_start, fetch_unit, op_access, op_odd, intermittent_en} = '0;
    {cpu_halt_len_bit0, cpu_halt_len_bit1, insn_end} = '0;
    addr_kind = BAC_BR_REL;
    fetch_bus = BAC_BUS_INT;
    op_bus = BAC_BUS_REG;
    op_size = BAC_SZ_BYTE;
    {pc, accumulator_low_half, rel_offset, code_bank_select} = '0;
    {data_bank_select, base_cycles, ea_addr, stall_len} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_branch();
    t_ops();
    t_halt();
    t_bare();
    results();
  end

  // watchdog well beyond the under two hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    results();
  end
endmodule : tb_top
`default_nettype wire
